// ---- rtl/bram_pkg.sv ----
// Shared constants and types for the embedded block RAM family.
// Assumes one system clock; the two block clocks arrive as strobes.
package bram_pkg;

    // Widest port of the family
    localparam int PORT_DW = 72;
    localparam int PORT_AW = 16;
    localparam int PORT_BE = 8;
    localparam int LANE_W = 9;

    // Capacity in bits, parity included
    localparam int SMALL_BITS = 576;
    localparam int MEDIUM_BITS = 4608;
    localparam int LARGE_BITS = 589824;

    // Native word width of each variant
    localparam int SMALL_DW = 18;
    localparam int MEDIUM_DW = 36;
    localparam int LARGE_DW = 72;

    // Address bits actually decoded by each variant
    localparam int SMALL_AW = 5;
    localparam int MEDIUM_AW = 7;
    localparam int LARGE_AW = 13;

    // Value shown by cleared data, address and byte-enable registers
    localparam logic [PORT_DW-1:0] DATA_RST = 72'h00_0000_0000_0000_0000;
    localparam logic [PORT_AW-1:0] ADDR_RST = 16'h0000;
    localparam logic [PORT_BE-1:0] BE_RST = 8'h00;

    typedef enum logic [1:0] {
        VAR_SMALL = 2'b00,
        VAR_MEDIUM = 2'b01,
        VAR_LARGE = 2'b10
    } variant_type;

    typedef enum logic [2:0] {
        MODE_TDP = 3'b000,
        MODE_SDP = 3'b001,
        MODE_SINGLE = 3'b010,
        MODE_FIFO = 3'b011,
        MODE_ROM = 3'b100,
        MODE_SHIFT = 3'b101
    } mode_type;

endpackage

// ---- rtl/bram_port.sv ----
// One port of a block RAM: input registers, read latch and output register.
// Assumes tick0/tick1 are one-cycle strobes on clk_sys; clears are asynchronous.
`timescale 1ns/1ps
module bram_port (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // The two block clocks as strobes
    input wire logic tick0,
    input wire logic tick1,
    // Configuration
    input wire logic in_sel,
    input wire logic out_sel,
    input wire logic out_bypass,
    input wire logic rd_ok,
    input wire logic wr_ok,
    // Request
    input wire logic clken,
    input wire logic addr_en,
    input wire logic rw,
    input wire logic [bram_pkg::PORT_AW-1:0] addr,
    input wire logic [bram_pkg::PORT_DW-1:0] din,
    input wire logic [bram_pkg::PORT_BE-1:0] be,
    // Clears
    input wire logic in_clr,
    input wire logic out_clr,
    // Array side
    output logic acc_ff,
    output logic rw_ff,
    output logic [bram_pkg::PORT_AW-1:0] addr_ff,
    output logic [bram_pkg::PORT_DW-1:0] din_ff,
    output logic [bram_pkg::PORT_BE-1:0] be_ff,
    input wire logic [bram_pkg::PORT_DW-1:0] rd_word,
    // Read data
    output logic [bram_pkg::PORT_DW-1:0] dout_ff
);
    logic in_tick;
    logic out_tick;
    logic capture;
    logic [bram_pkg::PORT_DW-1:0] rd_ff;

    // Each register group picks one of the two block clocks
    assign in_tick = in_sel ? tick1 : tick0;
    assign out_tick = out_sel ? tick1 : tick0;
    assign capture = in_tick & clken;

    // Input registers; port requests touch the array only from these, never from pins
    always_ff @(posedge clk_sys or posedge in_clr) begin
        if (in_clr) begin // [R15]
            acc_ff <= 1'b0;
            rw_ff <= 1'b0;
            addr_ff <= bram_pkg::ADDR_RST;
            din_ff <= bram_pkg::DATA_RST;
            be_ff <= bram_pkg::BE_RST;
        end else if (!rstn) begin
            acc_ff <= 1'b0;
            rw_ff <= 1'b0;
            addr_ff <= bram_pkg::ADDR_RST;
            din_ff <= bram_pkg::DATA_RST;
            be_ff <= bram_pkg::BE_RST;
        end else begin
            acc_ff <= capture & (rw ? wr_ok : rd_ok); // [R12] [R8]
            if (capture) begin
                rw_ff <= rw;
                din_ff <= din;
                be_ff <= be;
                if (addr_en) begin // Address clock enable [R13]
                    addr_ff <= addr;
                end
            end
        end
    end

    // Read latch and output register; only the output register may be bypassed
    always_ff @(posedge clk_sys or posedge out_clr) begin
        if (out_clr) begin // Seen at once, no edge needed [R16]
            rd_ff <= bram_pkg::DATA_RST;
            dout_ff <= bram_pkg::DATA_RST;
        end else if (!rstn) begin
            rd_ff <= bram_pkg::DATA_RST;
            dout_ff <= bram_pkg::DATA_RST;
        end else begin
            if (acc_ff && !rw_ff) begin
                rd_ff <= rd_word;
            end
            if (out_bypass) begin // [R4]
                if (acc_ff && !rw_ff) begin
                    dout_ff <= rd_word;
                end
            end else if (out_tick) begin
                dout_ff <= rd_ff;
            end
        end
    end

    sequence s_bypass_read;
        out_bypass && acc_ff && !rw_ff ##1 !out_clr;
    endsequence

    sequence s_out_load;
        !out_bypass && out_tick ##1 !out_clr;
    endsequence

    property p_in_clr;
        @(posedge clk_sys) in_clr |-> !acc_ff && addr_ff == bram_pkg::ADDR_RST;
    endproperty
    a_in_clr: assert property (p_in_clr) else $error("input clear not applied"); // [R15]

    property p_out_clr;
        @(posedge clk_sys) out_clr |-> dout_ff == bram_pkg::DATA_RST;
    endproperty
    a_out_clr: assert property (p_out_clr) else $error("output clear not seen"); // [R16]

    property p_no_stray_acc;
        @(posedge clk_sys) disable iff (!rstn || in_clr) !capture |=> !acc_ff;
    endproperty
    a_no_stray_acc: assert property (p_no_stray_acc) else $error("access without request"); // [R8]

    property p_capture;
        @(posedge clk_sys) disable iff (!rstn || in_clr)
            capture && (rw ? wr_ok : rd_ok) |=> acc_ff && rw_ff == $past(rw);
    endproperty
    a_capture: assert property (p_capture) else $error("request not registered"); // [R12]

    property p_bypass;
        @(posedge clk_sys) disable iff (!rstn) s_bypass_read |-> dout_ff == $past(rd_word);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass read wrong"); // [R4]

    property p_out_reg;
        @(posedge clk_sys) disable iff (!rstn) s_out_load |-> dout_ff == $past(rd_ff);
    endproperty
    a_out_reg: assert property (p_out_reg) else $error("output register wrong"); // [R4]

    property p_addr_hold;
        @(posedge clk_sys) disable iff (!rstn)
            capture && !addr_en ##1 !in_clr |-> $stable(addr_ff);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved while disabled"); // [R13]

endmodule

// ---- rtl/embedded_block_ram_family.sv ----
// Embedded block RAM, one of three sizes chosen by VARIANT.
// Assumes fabric logic on clk_sys drives all requests; the two block
// clocks arrive as one-cycle strobes, clears may arrive at any time.
//
// Functional notes
// R1 - Small: 576 bits; simple dual, single, FIFO, ROM, shift; no true dual-port.
// R2 - Small: write enable, data and address registers share one selected clock.
// R3 - Small: read address, read enable and output each pick either clock; here read address and read enable share one choice, in_sel_b.
// R4 - Small and medium: only the output register can be bypassed.
// R5 - Small: write/read enables, in/out clocks and output clear are inputs.
// R6 - Medium: 4,608 bits; all six modes including true dual-port.
// R7 - Medium: each register group may be clocked by either clock.
// R8 - Medium and large: ports A and B have independent clock, enable, select, clear.
// R9 - Small and medium: RAM or ROM contents can be preloaded.
// R10 - Large: 589,824 bits; true/simple dual, single, FIFO only.
// R11 - Large: no preload, array undefined until written.
// R12 - Large: synchronous only, all inputs registered, output register bypassable; here both clears act asynchronously.
// R13 - Port A: 72-bit data in/out, 16-bit address, 8 byte enables, controls.
// R14 - Port B mirrors port A with its own signals.
// R15 - Input clear acts at once; output changes only at next edge.
// R16 - Output clear acts on the output at once.
// R17 - Large: each byte enable gates one 9-bit lane; others keep value.
`timescale 1ns/1ps
module embedded_block_ram_family #(
    parameter bram_pkg::variant_type VARIANT = bram_pkg::VAR_LARGE
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // The two block clocks as strobes
    input wire logic tick0,
    input wire logic tick1,
    // Configuration
    input wire bram_pkg::mode_type mode,
    input wire logic in_sel_a,
    input wire logic out_sel_a,
    input wire logic out_bypass_a,
    input wire logic in_sel_b,
    input wire logic out_sel_b,
    input wire logic out_bypass_b,
    // Preload
    input wire logic init_en,
    input wire logic [bram_pkg::PORT_AW-1:0] init_addr,
    input wire logic [bram_pkg::PORT_DW-1:0] init_data,
    // Port A
    input wire logic clken_a,
    input wire logic addr_en_a,
    input wire logic rw_a,
    input wire logic [bram_pkg::PORT_AW-1:0] addr_a,
    input wire logic [bram_pkg::PORT_DW-1:0] din_a,
    input wire logic [bram_pkg::PORT_BE-1:0] be_a,
    input wire logic in_clr_a,
    input wire logic out_clr_a,
    output logic [bram_pkg::PORT_DW-1:0] dout_a,
    // Port B
    input wire logic clken_b,
    input wire logic addr_en_b,
    input wire logic rw_b,
    input wire logic [bram_pkg::PORT_AW-1:0] addr_b,
    input wire logic [bram_pkg::PORT_DW-1:0] din_b,
    input wire logic [bram_pkg::PORT_BE-1:0] be_b,
    input wire logic in_clr_b,
    input wire logic out_clr_b,
    output logic [bram_pkg::PORT_DW-1:0] dout_b
);
    localparam bit IS_SMALL = VARIANT == bram_pkg::VAR_SMALL;
    localparam bit IS_LARGE = VARIANT == bram_pkg::VAR_LARGE;
    localparam int DW = IS_SMALL ? bram_pkg::SMALL_DW :
        IS_LARGE ? bram_pkg::LARGE_DW : bram_pkg::MEDIUM_DW;
    localparam int AW = IS_SMALL ? bram_pkg::SMALL_AW :
        IS_LARGE ? bram_pkg::LARGE_AW : bram_pkg::MEDIUM_AW;
    localparam int BITS = IS_SMALL ? bram_pkg::SMALL_BITS :
        IS_LARGE ? bram_pkg::LARGE_BITS : bram_pkg::MEDIUM_BITS;
    localparam int DEPTH = BITS / DW;
    localparam int LANES = DW / bram_pkg::LANE_W;
    localparam bit HAS_TDP = !IS_SMALL; // [R1] [R6]
    localparam bit HAS_ROM = !IS_LARGE; // [R10]
    localparam bit HAS_INIT = !IS_LARGE; // [R9] [R11]

    logic [1:0] in_sel;
    logic [1:0] out_sel;
    logic [1:0] out_bypass;
    logic [1:0] clken;
    logic [1:0] addr_en;
    logic [1:0] rw;
    logic [1:0] in_clr;
    logic [1:0] out_clr;
    logic [1:0] wr_ok;
    logic [1:0] rd_ok;
    logic [1:0] acc;
    logic [1:0] acc_we;
    logic [1:0][bram_pkg::PORT_AW-1:0] addr;
    logic [1:0][bram_pkg::PORT_DW-1:0] din;
    logic [1:0][bram_pkg::PORT_BE-1:0] be;
    logic [1:0][bram_pkg::PORT_AW-1:0] acc_addr;
    logic [1:0][bram_pkg::PORT_DW-1:0] acc_din;
    logic [1:0][bram_pkg::PORT_BE-1:0] acc_be;
    logic [1:0][bram_pkg::PORT_DW-1:0] dout;
    wire [1:0][bram_pkg::PORT_DW-1:0] rd_word;
    logic [AW-1:0] idx [2];
    logic [AW-1:0] init_idx;
    logic init_wr;

    // Gather the two ports so one generate loop serves both [R8] [R13] [R14]
    assign in_sel = {in_sel_b, in_sel_a};
    assign out_sel = {out_sel_b, out_sel_a};
    assign out_bypass = {out_bypass_b, out_bypass_a};
    assign clken = {clken_b, clken_a};
    assign addr_en = {addr_en_b, addr_en_a};
    assign rw = {rw_b, rw_a};
    assign in_clr = {in_clr_b, in_clr_a};
    assign out_clr = {out_clr_b, out_clr_a};
    assign addr = {addr_b, addr_a};
    assign din = {din_b, din_a};
    assign be = {be_b, be_a};
    assign dout_a = dout[0];
    assign dout_b = dout[1];

    // Port roles per mode; a mode the variant lacks leaves the array idle.
    // FIFO and shift register use the simple dual-port roles: the fabric
    // keeps the pointers, which keeps the array identical in every mode.
    always_comb begin
        wr_ok = 2'b00;
        rd_ok = 2'b00;
        unique case (mode)
            bram_pkg::MODE_TDP: begin
                if (HAS_TDP) begin // [R1] [R6] [R10]
                    wr_ok = 2'b11;
                    rd_ok = 2'b11;
                end
            end
            bram_pkg::MODE_SDP, bram_pkg::MODE_FIFO: begin
                wr_ok = 2'b01; // A writes on its own clock choice [R2]
                rd_ok = 2'b10; // B reads on its own clock choices [R3] [R5]
            end
            bram_pkg::MODE_SHIFT: begin
                if (HAS_ROM) begin // [R10]
                    wr_ok = 2'b01;
                    rd_ok = 2'b10;
                end
            end
            bram_pkg::MODE_SINGLE: begin
                wr_ok = 2'b01;
                rd_ok = 2'b01;
            end
            bram_pkg::MODE_ROM: begin
                if (HAS_ROM) begin // [R10]
                    rd_ok = 2'b11;
                end
            end
            default: begin // Codes 6 and 7 are illegal
                wr_ok = 2'b00;
                rd_ok = 2'b00;
            end
        endcase
    end

    // Preload only where the variant has it and the mode is RAM or ROM
    assign init_wr = HAS_INIT && init_en && mode != bram_pkg::MODE_FIFO && // [R9] [R11]
        mode != bram_pkg::MODE_SHIFT;
    assign init_idx = init_addr[AW-1:0];

    // Per-port register stages; every request input is registered before use [R12] [R7]
    for (genvar p = 0; p < 2; p++) begin : g_port
        bram_port u_port (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .tick0(tick0),
            .tick1(tick1),
            .in_sel(in_sel[p]),
            .out_sel(out_sel[p]),
            .out_bypass(out_bypass[p]),
            .rd_ok(rd_ok[p]),
            .wr_ok(wr_ok[p]),
            .clken(clken[p]),
            .addr_en(addr_en[p]),
            .rw(rw[p]),
            .addr(addr[p]),
            .din(din[p]),
            .be(be[p]),
            .in_clr(in_clr[p]),
            .out_clr(out_clr[p]),
            .acc_ff(acc[p]),
            .rw_ff(acc_we[p]),
            .addr_ff(acc_addr[p]),
            .din_ff(acc_din[p]),
            .be_ff(acc_be[p]),
            .rd_word(rd_word[p]),
            .dout_ff(dout[p])
        );
        // Upper address bits beyond the variant's depth are ignored
        assign idx[p] = acc_addr[p][AW-1:0];
    end

    // One 9-bit memory per byte lane; lanes above the word width read zero.
    // The large array has no reset or preload, so it starts undefined [R11].
    for (genvar l = 0; l < bram_pkg::PORT_BE; l++) begin : g_lane
        if (l < LANES) begin : g_mem
            logic [bram_pkg::LANE_W-1:0] lane_mem [DEPTH]; // [R1] [R6] [R10]
            logic [bram_pkg::LANE_W-1:0] old_q;
            logic [AW-1:0] old_idx;

            // Port B is applied last, so it wins a same-address collision
            always_ff @(posedge clk_sys) begin
                if (init_wr) begin // [R9]
                    lane_mem[init_idx] <= init_data[l*bram_pkg::LANE_W +: bram_pkg::LANE_W];
                end
                for (int p = 0; p < 2; p++) begin
                    if (acc[p] && acc_we[p] && acc_be[p][l]) begin // [R17]
                        lane_mem[idx[p]] <= acc_din[p][l*bram_pkg::LANE_W +: bram_pkg::LANE_W];
                    end
                end
            end

            assign rd_word[0][l*bram_pkg::LANE_W +: bram_pkg::LANE_W] = lane_mem[idx[0]];
            assign rd_word[1][l*bram_pkg::LANE_W +: bram_pkg::LANE_W] = lane_mem[idx[1]];

            // Snapshot of the lane at port A's address, for the lane check
            always_ff @(posedge clk_sys) begin
                old_q <= lane_mem[idx[0]];
                old_idx <= idx[0];
            end

            property p_lane_keep;
                @(posedge clk_sys) disable iff (!rstn)
                    acc[0] && acc_we[0] && !acc_be[0][l] && !(acc[1] && acc_we[1])
                    && !init_wr |=> lane_mem[old_idx] == old_q;
            endproperty
            a_lane_keep: assert property (p_lane_keep) else $error("disabled lane changed"); // [R17]
        end else begin : g_none
            assign rd_word[0][l*bram_pkg::LANE_W +: bram_pkg::LANE_W] = 9'h000;
            assign rd_word[1][l*bram_pkg::LANE_W +: bram_pkg::LANE_W] = 9'h000;
        end
    end

    property p_small_roles;
        @(posedge clk_sys) disable iff (!rstn)
            IS_SMALL && mode == bram_pkg::MODE_TDP |-> wr_ok == 2'b00 && rd_ok == 2'b00;
    endproperty
    a_small_roles: assert property (p_small_roles) else $error("small block went true dual"); // [R1]

    property p_large_modes;
        @(posedge clk_sys) disable iff (!rstn)
            IS_LARGE && (mode == bram_pkg::MODE_ROM || mode == bram_pkg::MODE_SHIFT)
            |-> wr_ok == 2'b00 && rd_ok == 2'b00;
    endproperty
    a_large_modes: assert property (p_large_modes) else $error("large block took bad mode"); // [R10]

    property p_no_preload;
        @(posedge clk_sys) disable iff (!rstn) IS_LARGE && init_en |-> !init_wr;
    endproperty
    a_no_preload: assert property (p_no_preload) else $error("large block preloaded"); // [R11]

    property p_sdp_b_read_only;
        @(posedge clk_sys) disable iff (!rstn)
            mode == bram_pkg::MODE_SDP && acc[1] |-> !acc_we[1];
    endproperty
    a_sdp_b_read_only: assert property (p_sdp_b_read_only) else $error("read port wrote"); // [R3]

endmodule

// ---- sim/embedded_block_ram_family_test.sv ----
// Self-checking bench for the large block RAM variant, both ports.
// Assumes port input and output registers follow the fast block clock.
`timescale 1ns/1ps
module embedded_block_ram_family_test;
    localparam logic [71:0] D1 = 72'h12_3456_7890_abcd_ef01;
    localparam logic [71:0] D2 = 72'hfe_dcba_0987_6543_2110;
    localparam logic [71:0] D3 = 72'h5a_5a5a_a5a5_0f0f_f0f0;
    logic clk_sys, rstn, tick0, tick1;
    bram_pkg::mode_type mode;
    logic in_sel_a, out_sel_a, out_bypass_a, in_sel_b, out_sel_b, out_bypass_b;
    logic init_en;
    logic [15:0] init_addr, addr_a, addr_b;
    logic [71:0] init_data, din_a, din_b, dout_a, dout_b;
    logic clken_a, addr_en_a, rw_a, in_clr_a, out_clr_a;
    logic clken_b, addr_en_b, rw_b, in_clr_b, out_clr_b;
    logic [7:0] be_a, be_b;
    int num_errors = 0;
    int num_checks = 0;

    fabric_clocks #(.SLOW(4)) partner (.clk_sys(clk_sys), .rstn(rstn), .tick0(tick0),
        .tick1(tick1));

    embedded_block_ram_family #(.VARIANT(bram_pkg::VAR_LARGE)) DUT (
        .clk_sys(clk_sys), .rstn(rstn), .tick0(tick0), .tick1(tick1), .mode(mode),
        .in_sel_a(in_sel_a), .out_sel_a(out_sel_a), .out_bypass_a(out_bypass_a),
        .in_sel_b(in_sel_b), .out_sel_b(out_sel_b), .out_bypass_b(out_bypass_b),
        .init_en(init_en), .init_addr(init_addr), .init_data(init_data),
        .clken_a(clken_a), .addr_en_a(addr_en_a), .rw_a(rw_a), .addr_a(addr_a),
        .din_a(din_a), .be_a(be_a), .in_clr_a(in_clr_a), .out_clr_a(out_clr_a),
        .dout_a(dout_a), .clken_b(clken_b), .addr_en_b(addr_en_b), .rw_b(rw_b),
        .addr_b(addr_b), .din_b(din_b), .be_b(be_b), .in_clr_b(in_clr_b),
        .out_clr_b(out_clr_b), .dout_b(dout_b));

    // System clock, 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Expected word after a lane-gated write of nw over ow
    function automatic logic [71:0] merge(logic [71:0] ow, logic [71:0] nw, logic [7:0] be);
        logic [71:0] r;
        r = ow;
        for (int l = 0; l < 8; l++) begin
            if (be[l]) r[l*9 +: 9] = nw[l*9 +: 9];
        end
        return r;
    endfunction

    task automatic chk(string name, logic [71:0] exp, logic [71:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    // Present a request on one port; it is taken at the next edge
    task automatic put(bit p, logic rw, logic [15:0] ad, logic [71:0] d, logic [7:0] be);
        if (!p) begin
            clken_a <= 1'b1; rw_a <= rw; addr_a <= ad; din_a <= d; be_a <= be;
        end else begin
            clken_b <= 1'b1; rw_b <= rw; addr_b <= ad; din_b <= d; be_b <= be;
        end
    endtask

    // Capture edge, then n more edges; sample just after the last one
    task automatic run(int n);
        @(posedge clk_sys);
        clken_a <= 1'b0;
        clken_b <= 1'b0;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        #100000;
        num_errors++;
        results();
    end

    initial begin
        rstn = 1'b0; mode = bram_pkg::MODE_TDP; init_en = 1'b0;
        init_addr = 16'h0000; init_data = 72'h00_0000_0000_0000_0000;
        in_sel_a = 1'b0; out_sel_a = 1'b0; out_bypass_a = 1'b1;
        in_sel_b = 1'b0; out_sel_b = 1'b0; out_bypass_b = 1'b1;
        clken_a = 1'b0; addr_en_a = 1'b1; rw_a = 1'b0; addr_a = 16'h0000;
        din_a = '0; be_a = 8'h00; in_clr_a = 1'b0; out_clr_a = 1'b0;
        clken_b = 1'b0; addr_en_b = 1'b1; rw_b = 1'b0; addr_b = 16'h0000;
        din_b = '0; be_b = 8'h00; in_clr_b = 1'b0; out_clr_b = 1'b0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        // Full word through port A, partial lanes through port B
        @(posedge clk_sys); put(0, 1, 16'h0005, D1, 8'hff); run(2);
        @(posedge clk_sys); put(0, 0, 16'h0005, D1, 8'hff); run(2);
        chk("dout_a full", D1, dout_a);
        @(posedge clk_sys); put(1, 1, 16'h0005, D2, 8'h0f); run(2);
        @(posedge clk_sys); put(1, 0, 16'h0005, D2, 8'h00); run(2);
        chk("dout_b lanes", merge(D1, D2, 8'h0f), dout_b);
        // Same-cycle writes from both ports, B owns lane 0
        @(posedge clk_sys); put(0, 1, 16'h0006, D3, 8'hff); put(1, 1, 16'h0006, D2, 8'h01);
        run(2);
        @(posedge clk_sys); put(0, 0, 16'h0006, D3, 8'h00); run(2);
        chk("dout_a collide", merge(D3, D2, 8'h01), dout_a);
        // ROM code is refused on the large block, preload is ignored
        @(posedge clk_sys); mode <= bram_pkg::MODE_ROM; put(0, 1, 16'h0005, D3, 8'hff);
        run(2);
        @(posedge clk_sys); mode <= bram_pkg::MODE_TDP; init_en <= 1'b1;
        init_addr <= 16'h0005; init_data <= D3;
        @(posedge clk_sys); init_en <= 1'b0; put(0, 0, 16'h0005, D1, 8'h00); run(2);
        chk("dout_a no rom", merge(D1, D2, 8'h0f), dout_a);
        // Address enable low keeps the last address; unselected lanes must survive
        @(posedge clk_sys); addr_en_a <= 1'b0; put(0, 1, 16'h0007, D3, 8'h0f); run(2);
        @(posedge clk_sys); addr_en_a <= 1'b1; put(0, 0, 16'h0005, D1, 8'h00); run(2);
        chk("dout_a addr hold", merge(D1, D3, 8'h0f), dout_a);
        // Simple dual-port: port B may read, but its write is dropped
        @(posedge clk_sys); mode <= bram_pkg::MODE_SDP;
        put(1, 1, 16'h0005, D2, 8'hff); run(2);
        @(posedge clk_sys); put(1, 0, 16'h0005, D2, 8'h00); run(2);
        chk("dout_b sdp", merge(D1, D3, 8'h0f), dout_b);
        // Registered output lags the bypassed path by one block clock
        @(posedge clk_sys); mode <= bram_pkg::MODE_TDP; out_bypass_a <= 1'b0;
        put(0, 0, 16'h0006, D1, 8'h00); run(1);
        chk("dout_a held", merge(D1, D3, 8'h0f), dout_a);
        @(posedge clk_sys); #1;
        chk("dout_a registered", merge(D3, D2, 8'h01), dout_a);
        // Output clear is seen without a clock edge
        @(posedge clk_sys); out_clr_a <= 1'b1; #1;
        chk("dout_a out clear", 72'h00_0000_0000_0000_0000, dout_a);
        @(posedge clk_sys); out_clr_a <= 1'b0; out_bypass_a <= 1'b1;
        // Input clear kills a captured read before it reaches the array
        @(posedge clk_sys); put(0, 0, 16'h0005, D1, 8'h00);
        @(posedge clk_sys); clken_a <= 1'b0; in_clr_a <= 1'b1;
        @(posedge clk_sys); in_clr_a <= 1'b0;
        repeat (2) @(posedge clk_sys); #1;
        chk("dout_a in clear", 72'h00_0000_0000_0000_0000, dout_a);
        results();
    end
endmodule

// ---- sim/fabric_clocks.sv ----
// Fabric-side model that supplies the two block clocks as strobes.
// Assumes it shares clk_sys and rstn with the block RAM.
`timescale 1ns/1ps
module fabric_clocks #(
    parameter int SLOW = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Block clock strobes
    output logic tick0,
    output logic tick1
);
    logic [7:0] cnt_ff;

    // Fast clock every cycle, slow clock once per SLOW cycles; quiet in reset
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_ff <= 8'h00;
            tick0 <= 1'b0;
            tick1 <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff == 8'(SLOW - 1)) ? 8'h00 : cnt_ff + 8'h01;
            tick0 <= 1'b1;
            tick1 <= (cnt_ff == 8'h00);
        end
    end
endmodule
